// ==== rtcnv_pkg.sv ====
// Package with offsets, field positions, reset values and types of the non-volatile register bank
package rtcnv_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] TEMP_VALUE_ADDR    = 8'h20;
	localparam logic [7:0] USER_NV_BYTE0_ADDR = 8'h28;
	localparam logic [7:0] USER_NV_BYTE1_ADDR = 8'h29;
	localparam logic [7:0] NV_CONFIG_ADDR     = 8'h30;
	localparam logic [7:0] XTAL_TRIM_ADDR     = 8'h31;
	localparam logic [7:0] XTAL_COEF_ADDR     = 8'h32;
	localparam logic [7:0] TURNOVER_ADDR      = 8'h33;

	// ----------------------------------------------------------------
	// Non-volatile image slots, in load order
	// ----------------------------------------------------------------
	localparam int          NV_SLOTS        = 6;
	localparam logic [2:0]  SLOT_USER0      = 3'h0;
	localparam logic [2:0]  SLOT_USER1      = 3'h1;
	localparam logic [2:0]  SLOT_CONFIG     = 3'h2;
	localparam logic [2:0]  SLOT_TRIM       = 3'h3;
	localparam logic [2:0]  SLOT_COEF       = 3'h4;
	localparam logic [2:0]  SLOT_TURNOVER   = 3'h5;
	localparam logic [2:0]  SLOT_LAST       = 3'h5;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_TRICKLE_80K_BIT  = 7;
	localparam int CFG_TRICKLE_20K_BIT  = 6;
	localparam int CFG_TRICKLE_5K_BIT   = 5;
	localparam int CFG_TRICKLE_1K5_BIT  = 4;
	localparam int CFG_CLKSEL_HI_BIT    = 3;
	localparam int CFG_CLKSEL_LO_BIT    = 2;
	localparam int CFG_THERMO_EN_BIT    = 1;
	localparam int CFG_SCAN_PERIOD_BIT  = 0;
	localparam int TRIM_SIGN_BIT        = 7;
	localparam logic [6:0] TRIM_MAG_MAX = 7'h79;

	// ----------------------------------------------------------------
	// Reset values of the working copies, before the load completes
	// ----------------------------------------------------------------
	localparam logic [7:0] WORK_RESET_VALUE = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LOAD_ISSUE,
		LOAD_TAKE,
		RUNNING
	} rtcnv_phase_e;

	typedef struct packed {
		logic       trickle_eighty_kohm_en;
		logic       trickle_twenty_kohm_en;
		logic       trickle_five_kohm_en;
		logic       trickle_one_half_kohm_en;
		logic       clock_out_sel_hi;
		logic       clock_out_sel_lo;
		logic       thermometerEn;
		logic       temp_scan_period;
	} rtcnv_config_s;

	typedef struct packed {
		logic       trimFast;
		logic [6:0] trimMagnitude;
		logic [7:0] crystalCoef;
		logic [7:0] turnover_temperature;
	} rtcnv_comp_s;
endpackage

// ==== rtc_nv_config_regs.sv ====
// Non-volatile configuration, trim and user storage register bank
`timescale 1ns/10ps
// Notes on behaviour
// - Two 8-bit user bytes at 28h and 29h hold any value 0 to 255.
// - Control page holds configuration, offset trim, coefficient and turnover temperature.
// - Config bits 7..4 each enable one trickle resistor: 80k, 20k, 5k, 1.5k.
// - Config bits 3..2 form a code selecting the clock output frequency.
// - Config bit 1 enables the thermometer; clear disables temperature measurement.
// - Config bit 0 picks scan interval; 1 means every 16 seconds.
// - Offset, coefficient and turnover values are driven out for oscillator compensation.
// - Trim bits 6..0 are magnitude 0 to 121; bit 7 is sign, 1 fast.
// - With thermometer disabled the host may write temperature at 20h.
module rtc_nv_config_regs (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_b,
	// Register port from the serial interface decoder
	input  wire logic [7:0]              regAddr,
	input  wire logic                    regWrEn,
	input  wire logic                    regRdEn,
	input  wire logic [7:0]              regWrData,
	output logic      [7:0]              regRdData,
	output logic                         regRdValid,
	output logic                         regBusy,
	// Non-volatile store, one-cycle read latency
	output logic      [2:0]              nvRdIndex,
	input  wire logic [7:0]              nvRdData,
	output logic                         nvWrEn,
	output logic      [2:0]              nvWrIndex,
	output logic      [7:0]              nvWrData,
	// Thermometer result
	input  wire logic                    tempMeasValid,
	input  wire logic [7:0]              tempMeasData,
	// Settings to the rest of the module
	output rtcnv_pkg::rtcnv_config_s     configOut,
	output rtcnv_pkg::rtcnv_comp_s       compOut,
	output logic      [7:0]              temperatureValue,
	output logic      [7:0]              userByte0,
	output logic      [7:0]              userByte1
);

	// ----------------------------------------------------------------
	// Storage and helpers
	// ----------------------------------------------------------------
	logic [7:0]              workCopy [rtcnv_pkg::NV_SLOTS];
	rtcnv_pkg::rtcnv_phase_e phase;
	logic [2:0]              loadIndex;
	logic [2:0]              wrSlot;
	logic                    wrHit;
	logic [7:0]              wrValue;
	logic [3:0]              addrSlot;

	// Maps a bus address onto an image slot
	function automatic logic [3:0] slot_of(input logic [7:0] addr);
		unique case (addr)
			rtcnv_pkg::USER_NV_BYTE0_ADDR: slot_of = {1'b1, rtcnv_pkg::SLOT_USER0};
			rtcnv_pkg::USER_NV_BYTE1_ADDR: slot_of = {1'b1, rtcnv_pkg::SLOT_USER1};
			rtcnv_pkg::NV_CONFIG_ADDR:     slot_of = {1'b1, rtcnv_pkg::SLOT_CONFIG};
			rtcnv_pkg::XTAL_TRIM_ADDR:     slot_of = {1'b1, rtcnv_pkg::SLOT_TRIM};
			rtcnv_pkg::XTAL_COEF_ADDR:     slot_of = {1'b1, rtcnv_pkg::SLOT_COEF};
			rtcnv_pkg::TURNOVER_ADDR:      slot_of = {1'b1, rtcnv_pkg::SLOT_TURNOVER};
			default:                       slot_of = 4'h0;
		endcase
	endfunction

	// Clamps a trim byte so the magnitude never exceeds its legal top
	function automatic logic [7:0] clamp_trim(input logic [7:0] value);
		if (value[6:0] > rtcnv_pkg::TRIM_MAG_MAX) begin
			clamp_trim = {value[rtcnv_pkg::TRIM_SIGN_BIT], rtcnv_pkg::TRIM_MAG_MAX};
		end else begin
			clamp_trim = value;
		end
	endfunction

	// ----------------------------------------------------------------
	// Power-up load sequencer
	// ----------------------------------------------------------------
	// Walks the image one slot at a time; the bank refuses host access meanwhile
	// load before use
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase     <= rtcnv_pkg::LOAD_ISSUE;
			loadIndex <= 3'h0;
		end else begin
			unique case (phase)
				rtcnv_pkg::LOAD_ISSUE: begin
					phase <= rtcnv_pkg::LOAD_TAKE;
				end
				rtcnv_pkg::LOAD_TAKE: begin
					if (loadIndex == rtcnv_pkg::SLOT_LAST) begin
						phase <= rtcnv_pkg::RUNNING;
					end else begin
						phase     <= rtcnv_pkg::LOAD_ISSUE;
						loadIndex <= loadIndex + 3'h1;
					end
				end
				rtcnv_pkg::RUNNING: begin
					phase <= rtcnv_pkg::RUNNING;
				end
			endcase
		end
	end

	assign regBusy   = (phase != rtcnv_pkg::RUNNING);
	assign nvRdIndex = loadIndex;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	// Slot lookup shared by the write decode and the read port
	assign addrSlot = slot_of(regAddr);

	// decode of the six stored bytes
	always_comb begin
		wrHit   = regWrEn && !regBusy && addrSlot[3];
		wrSlot  = addrSlot[2:0];
		wrValue = regWrData;
		if (wrSlot == rtcnv_pkg::SLOT_TRIM) begin
			wrValue = clamp_trim(regWrData);
		end
	end

	// ----------------------------------------------------------------
	// Working copies
	// ----------------------------------------------------------------
	// Loaded from the store at power-up, then updated by host writes
	// working copy load
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < rtcnv_pkg::NV_SLOTS; i++) begin
				workCopy[i] <= rtcnv_pkg::WORK_RESET_VALUE;
			end
		end else if (phase == rtcnv_pkg::LOAD_TAKE) begin
			if (loadIndex == rtcnv_pkg::SLOT_TRIM) begin
				workCopy[loadIndex] <= clamp_trim(nvRdData);
			end else begin
				workCopy[loadIndex] <= nvRdData;
			end
		end else if (wrHit) begin
			workCopy[wrSlot] <= wrValue;
		end
	end

	// Every accepted write to one of the six stored bytes is also committed to the store
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			nvWrEn    <= 1'b0;
			nvWrIndex <= 3'h0;
			nvWrData  <= 8'h00;
		end else begin
			nvWrEn <= wrHit;
			if (wrHit) begin
				nvWrIndex <= wrSlot;
				nvWrData  <= wrValue;
			end
		end
	end

	// ----------------------------------------------------------------
	// Temperature value
	// ----------------------------------------------------------------
	// Host write allowed only while the thermometer is off, so a measurement
	// never races a host write
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			temperatureValue <= 8'h00;
		end else if (configOut.thermometerEn) begin
			if (tempMeasValid) begin
				temperatureValue <= tempMeasData;
			end
		end else if (regWrEn && !regBusy && regAddr == rtcnv_pkg::TEMP_VALUE_ADDR) begin
			temperatureValue <= regWrData;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Unmapped addresses read as zero; data is ready the cycle after the request
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData  <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn && !regBusy;
			if (regRdEn && !regBusy) begin
				if (addrSlot[3]) begin
					regRdData <= workCopy[addrSlot[2:0]];
				end else if (regAddr == rtcnv_pkg::TEMP_VALUE_ADDR) begin
					regRdData <= temperatureValue;
				end else begin
					regRdData <= 8'h00;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Settings outputs
	// ----------------------------------------------------------------
	// Configuration outputs held at zero until the load completes; compensation and user byte outputs follow the working copies directly
	// configuration outputs: trickle enables, clock select, thermometer enable, scan period
	assign configOut.trickle_eighty_kohm_en =
		!regBusy && workCopy[rtcnv_pkg::SLOT_CONFIG][rtcnv_pkg::CFG_TRICKLE_80K_BIT];
	assign configOut.trickle_twenty_kohm_en =
		!regBusy && workCopy[rtcnv_pkg::SLOT_CONFIG][rtcnv_pkg::CFG_TRICKLE_20K_BIT];
	assign configOut.trickle_five_kohm_en =
		!regBusy && workCopy[rtcnv_pkg::SLOT_CONFIG][rtcnv_pkg::CFG_TRICKLE_5K_BIT];
	assign configOut.trickle_one_half_kohm_en =
		!regBusy && workCopy[rtcnv_pkg::SLOT_CONFIG][rtcnv_pkg::CFG_TRICKLE_1K5_BIT];
	assign configOut.clock_out_sel_hi =
		!regBusy && workCopy[rtcnv_pkg::SLOT_CONFIG][rtcnv_pkg::CFG_CLKSEL_HI_BIT];
	assign configOut.clock_out_sel_lo =
		!regBusy && workCopy[rtcnv_pkg::SLOT_CONFIG][rtcnv_pkg::CFG_CLKSEL_LO_BIT];
	assign configOut.thermometerEn =
		!regBusy && workCopy[rtcnv_pkg::SLOT_CONFIG][rtcnv_pkg::CFG_THERMO_EN_BIT];
	assign configOut.temp_scan_period =
		!regBusy && workCopy[rtcnv_pkg::SLOT_CONFIG][rtcnv_pkg::CFG_SCAN_PERIOD_BIT];

	assign compOut.trimFast             = workCopy[rtcnv_pkg::SLOT_TRIM][rtcnv_pkg::TRIM_SIGN_BIT];
	assign compOut.trimMagnitude        = workCopy[rtcnv_pkg::SLOT_TRIM][6:0];
	assign compOut.crystalCoef          = workCopy[rtcnv_pkg::SLOT_COEF];
	assign compOut.turnover_temperature = workCopy[rtcnv_pkg::SLOT_TURNOVER];

	assign userByte0 = workCopy[rtcnv_pkg::SLOT_USER0];
	assign userByte1 = workCopy[rtcnv_pkg::SLOT_USER1];

endmodule

// ==== rtc_nv_config_regs_chk.sv ====
// Checker with the concurrent properties of the non-volatile register bank
`timescale 1ns/10ps
module rtc_nv_cfg_chk (
	input wire logic                    sys_clk,
	input wire logic                    rst_b,
	input wire logic [7:0]              regAddr,
	input wire logic                    regWrEn,
	input wire logic                    regRdEn,
	input wire logic [7:0]              regWrData,
	input wire logic                    regRdValid,
	input wire logic                    regBusy,
	input wire logic                    nvWrEn,
	input wire logic [2:0]              nvWrIndex,
	input wire logic [7:0]              nvWrData,
	input wire logic                    tempMeasValid,
	input wire logic [7:0]              tempMeasData,
	input wire rtcnv_pkg::rtcnv_config_s configOut,
	input wire rtcnv_pkg::rtcnv_comp_s   compOut,
	input wire logic [7:0]              temperatureValue,
	input wire logic [7:0]              userByte0
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------------------------------
	// Edges since reset release, saturating so it never wraps
	// ----------------------------------------------------------------
	logic [3:0] relCount;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) relCount <= 4'h0;
		else if (relCount != 4'hF) relCount <= relCount + 4'h1;
	end
	a_load_length: assert property (regBusy == (relCount < 4'hC))
		else $error("load window length wrong");
	a_cfg_hidden: assert property (regBusy |-> configOut == 8'h00)
		else $error("settings visible during load");
	a_rd_answer: assert property (regRdEn && !regBusy |=> regRdValid)
		else $error("read not answered");
	a_rd_unasked: assert property (regRdValid |-> $past(regRdEn) && !$past(regBusy))
		else $error("read answer without request");
	a_user_write: assert property (regWrEn && !regBusy
		&& regAddr == rtcnv_pkg::USER_NV_BYTE0_ADDR |=> userByte0 == $past(regWrData))
		else $error("user byte not written");
	// Settings and the store pulse both show up in the cycle after the write
	a_cfg_store: assert property (regWrEn && !regBusy
		&& regAddr == rtcnv_pkg::NV_CONFIG_ADDR |=> configOut == $past(regWrData)
		&& nvWrEn && nvWrIndex == rtcnv_pkg::SLOT_CONFIG && nvWrData == $past(regWrData))
		else $error("configuration write wrong");
	a_trim_range: assert property (compOut.trimMagnitude <= rtcnv_pkg::TRIM_MAG_MAX)
		else $error("trim magnitude above limit");
	a_temp_locked: assert property (regWrEn && !regBusy && !tempMeasValid
		&& configOut.thermometerEn && regAddr == rtcnv_pkg::TEMP_VALUE_ADDR
		|=> $stable(temperatureValue))
		else $error("temperature written while measuring");
	a_temp_meas: assert property (tempMeasValid && configOut.thermometerEn && !regBusy
		|=> temperatureValue == $past(tempMeasData))
		else $error("measurement not taken");
endmodule
bind rtc_nv_config_regs rtc_nv_cfg_chk i_chk (
	.sys_clk          (sys_clk),
	.rst_b            (rst_b),
	.regAddr          (regAddr),
	.regWrEn          (regWrEn),
	.regRdEn          (regRdEn),
	.regWrData        (regWrData),
	.regRdValid       (regRdValid),
	.regBusy          (regBusy),
	.nvWrEn           (nvWrEn),
	.nvWrIndex        (nvWrIndex),
	.nvWrData         (nvWrData),
	.tempMeasValid    (tempMeasValid),
	.tempMeasData     (tempMeasData),
	.configOut        (configOut),
	.compOut          (compOut),
	.temperatureValue (temperatureValue),
	.userByte0        (userByte0)
);

// ==== rtc_nv_config_regs_bench.sv ====
// Self-checking bench for the non-volatile register bank
`timescale 1ns/10ps
module rtc_nv_config_regs_bench;
	logic sys_clk, rst_b, regWrEn, regRdEn, regRdValid, regBusy, nvWrEn, tempMeasValid;
	logic [7:0] regAddr, regWrData, regRdData, nvRdData, nvWrData, tempMeasData;
	logic [7:0] temperatureValue, userByte0, userByte1;
	logic [2:0] nvRdIndex, nvWrIndex;
	rtcnv_pkg::rtcnv_config_s configOut;
	rtcnv_pkg::rtcnv_comp_s   compOut;
	int nFail = 0, testsRun = 0;
	// Stored image: config all ones, trim above limit to see the clamp
	logic [7:0] img [6] = '{8'hA5, 8'h5A, 8'hFF, 8'hFF, 8'h12, 8'h34};
	// Store write seen in the one cycle it stands
	logic [11:0] nvSeen;
	rtc_nv_config_regs i_dut (
		.sys_clk          (sys_clk),
		.rst_b            (rst_b),
		.regAddr          (regAddr),
		.regWrEn          (regWrEn),
		.regRdEn          (regRdEn),
		.regWrData        (regWrData),
		.regRdData        (regRdData),
		.regRdValid       (regRdValid),
		.regBusy          (regBusy),
		.nvRdIndex        (nvRdIndex),
		.nvRdData         (nvRdData),
		.nvWrEn           (nvWrEn),
		.nvWrIndex        (nvWrIndex),
		.nvWrData         (nvWrData),
		.tempMeasValid    (tempMeasValid),
		.tempMeasData     (tempMeasData),
		.configOut        (configOut),
		.compOut          (compOut),
		.temperatureValue (temperatureValue),
		.userByte0        (userByte0),
		.userByte1        (userByte1)
	);
	// Store answers on the falling edge after the index, half a cycle later, within the one cycle the load allows
	always @(negedge sys_clk) nvRdData <= img[nvRdIndex];
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic endSim();
		$display("checks %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Two cycles per access so strobes never rise and fall in one step;
	// the store pulse lasts one cycle, so it is caught right after the write edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge sys_clk) regWrEn = 1'b0;
		nvSeen = {nvWrEn, nvWrIndex, nvWrData};
		@(negedge sys_clk);
	endtask
	// Read answer is looked at while its valid pulse stands
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge sys_clk) regRdEn = 1'b0;
		chk({regRdValid, regRdData}, {1'b1, exp});
		@(negedge sys_clk);
	endtask
	task automatic waitLoad();
		for (int k = 0; k < 40 && regBusy !== 1'b0; k++) @(negedge sys_clk);
		if (regBusy !== 1'b0) begin
			nFail++;
			endSim();
		end
	endtask
	initial begin
		logic [7:0] v;
		{rst_b, regWrEn, regRdEn, tempMeasValid} = 4'h0;
		{regAddr, regWrData, tempMeasData} = 24'h00_0000;
		repeat (16) @(negedge sys_clk);
		chk(regBusy, 1'b1);
		rst_b = 1'b1;
		waitLoad();
		chk({userByte0, userByte1, configOut}, {8'hA5, 8'h5A, 8'hFF});
		chk(nvRdIndex, rtcnv_pkg::SLOT_LAST);
		chk(compOut, {8'hF9, 8'h12, 8'h34});
		$display("test load done");
		// every field bit and clock code
		for (int i = 0; i < 12; i++) begin
			v = (i < 8) ? 8'h01 << i : 8'((i - 8) << 2);
			wr(rtcnv_pkg::NV_CONFIG_ADDR, v);
			chk({nvSeen, configOut}, {1'b1, 3'h2, v, v});
		end
		$display("test config done");
		wr(8'h31, 8'h7F);
		rd(8'h31, 8'h79);
		chk(compOut[23:16], 8'h79);
		wr(8'h31, 8'hF9);
		rd(8'h31, 8'hF9);
		wr(8'h28, 8'hFF);
		wr(8'h29, 8'h00);
		rd(8'h28, 8'hFF);
		rd(8'h29, 8'h00);
		rd(8'h40, 8'h00);
		$display("test bytes done");
		// temperature writable only while thermometer off
		wr(8'h20, 8'h3C);
		chk(temperatureValue, 8'h3C);
		tempMeasData = 8'h55;
		tempMeasValid = 1'b1;
		@(negedge sys_clk) tempMeasValid = 1'b0;
		chk(temperatureValue, 8'h3C);
		wr(8'h30, 8'h02);
		wr(8'h20, 8'h11);
		chk(temperatureValue, 8'h3C);
		tempMeasData = 8'h77;
		tempMeasValid = 1'b1;
		@(negedge sys_clk) tempMeasValid = 1'b0;
		chk(temperatureValue, 8'h77);
		$display("test temperature done");
		// second reset, write during load refused
		rst_b = 1'b0;
		@(negedge sys_clk) rst_b = 1'b1;
		wr(8'h28, 8'h00);
		waitLoad();
		chk({userByte0, configOut}, {8'hA5, 8'hFF});
		$display("test reload done");
		endSim();
	end
endmodule
